// ==== rtl/jid_jump_and_increment_decode.sv ====
// Decode and execute of the absolute jump and the file register increment
`timescale 1ns/10ps
module jid_jump_and_increment_decode
(
   input  wire logic             clk,          // 125 MHz core clock
   input  wire logic             rst,          // Synchronous, active high
   input  wire logic [15:0]      instrWord,    // Current instruction word, valid in Q1
   input  wire logic [15:0]      instrNext,    // Following program word, valid in Q4
   input  wire logic [3:0]       bankSelect,   // Bank select register value
   input  wire logic [11:0]      indexBase,    // Base pointer for indexed addressing
   input  wire logic [7:0]       memRdata,     // File register read data, sampled in Q2
   output jid_pkg::jid_mem_s     memReq,       // File register address and write
   output jid_pkg::jid_phase_e   phase,        // Current instruction phase
   output logic [20:0]           pc,           // Program counter
   output jid_pkg::jid_flags_s   flags,        // Status flags
   output logic [7:0]            workReg,      // Working register
   input  wire logic [1:0]       regAddr,      // Register port address
   input  wire logic [7:0]       regWdata,     // Register port write data
   input  wire logic             regWr,        // Register port write strobe
   input  wire logic             regRd,        // Register port read strobe
   output logic [7:0]            regRdata      // Read data, cycle after strobe
);

   // Whole block state in one record
   typedef struct packed {
      jid_pkg::jid_phase_e phase;     // Phase counter
      logic [20:0]         pc;        // Program counter
      logic [7:0]          work;      // Working register
      jid_pkg::jid_flags_s flags;     // Status flags
      logic [7:0]          ctrl;      // Control register
      logic                flush;     // Current cycle is the idle jump tail
      logic                isJump;    // Current cycle is a jump
      logic                isInc;     // Current cycle is an increment
      logic                dBit;      // Destination select
      logic [7:0]          kLow;      // Low jump target byte
      logic [7:0]          operand;   // Value read from file register
      logic [8:0]          sum;       // Operand plus one, with carry
      jid_pkg::jid_flags_s incFlags;  // Flags computed in Q3
      jid_pkg::jid_mem_s   mem;       // Data memory request
      logic [7:0]          rdata;     // Register port read data
   } jid_state_s;

   jid_state_s state;       // Registered state
   jid_state_s next_state;  // Next value

   // First jump word match
   function automatic logic isJumpWord(input logic [15:0] w);
      isJumpWord = (w[15:8] == jid_pkg::JUMP_OPCODE);
   endfunction : isJumpWord

   // Increment opcode match
   function automatic logic isIncWord(input logic [15:0] w);
      isIncWord = (w[15:10] == jid_pkg::INC_OPCODE);
   endfunction : isIncWord

   // Effective file address for byte operands
   function automatic logic [11:0] effAddr(input logic [15:0] w, input logic ext,
                                           input logic [3:0] bank, input logic [11:0] base);
      logic [7:0] f;
      f = w[7:0];
      if (w[jid_pkg::INC_A_BIT])
         effAddr = {bank, f};
      else if (ext && f <= jid_pkg::INDEX_LIMIT)
         effAddr = base + {4'h0, f};
      else if (f < jid_pkg::ACCESS_SPLIT)
         effAddr = {jid_pkg::ACCESS_LOW, f};
      else
         effAddr = {jid_pkg::ACCESS_HIGH, f};
   endfunction : effAddr

   // Next state: phase walk, decode, execute and register port
   always_comb
   begin
      next_state = state;
      next_state.mem.we = 1'b0;
      next_state.rdata = 8'h00;
      unique case (state.phase)
         jid_pkg::Q1:
         begin
            // Decode; the idle tail of a jump decodes nothing
            next_state.phase = jid_pkg::Q2;
            next_state.isJump = !state.flush && isJumpWord(instrWord);
            next_state.isInc = !state.flush && isIncWord(instrWord);
            next_state.dBit = instrWord[jid_pkg::INC_D_BIT];
            next_state.mem.addr = effAddr(instrWord, state.ctrl[jid_pkg::CTRL_EXT_BIT],
                                          bankSelect, indexBase);
            next_state.kLow = instrWord[7:0];
         end
         jid_pkg::Q2:
         begin
            // Read the file register; the jump keeps its low byte latched
            next_state.phase = jid_pkg::Q3;
            next_state.operand = memRdata;
         end
         jid_pkg::Q3:
         begin
            // Add one and prepare flags and the write strobe
            next_state.phase = jid_pkg::Q4;
            next_state.sum = {1'b0, state.operand} + jid_pkg::INC_ONE;
            next_state.incFlags.c = next_state.sum[8];
            next_state.incFlags.dc = (state.operand[3:0] == 4'hF);
            next_state.incFlags.n = next_state.sum[7];
            next_state.incFlags.z = (next_state.sum[7:0] == 8'h00);
            next_state.incFlags.ov = (state.operand == jid_pkg::SIGNED_MAX);
            next_state.mem.wdata = next_state.sum[7:0];
            next_state.mem.we = state.isInc && state.dBit;
         end
         jid_pkg::Q4:
         begin
            // Write back and move the program counter
            next_state.phase = jid_pkg::Q1;
            next_state.flush = 1'b0;
            next_state.pc = state.pc + jid_pkg::PC_STEP;
            if (state.isInc)
            begin
               next_state.flags = state.incFlags;
               if (!state.dBit)
                  next_state.work = state.sum[7:0];
            end
            // A malformed second word is treated as no jump at all
            if (state.isJump && instrNext[15:12] == jid_pkg::JUMP_PREFIX)
            begin
               next_state.pc = {instrNext[11:0], state.kLow, 1'b0};
               next_state.flush = 1'b1;
            end
            next_state.isJump = 1'b0;
            next_state.isInc = 1'b0;
         end
      endcase
      // Software writes; a write to the working register yields to the core in Q4
      if (regWr)
      begin
         if (regAddr == jid_pkg::REG_CTRL)
            next_state.ctrl = regWdata;
         else if (regAddr == jid_pkg::REG_WORK && !(state.phase == jid_pkg::Q4 && state.isInc && !state.dBit))
            next_state.work = regWdata;
      end
      // Read data appears in the cycle after the strobe only
      if (regRd)
      begin
         unique case (regAddr)
            jid_pkg::REG_CTRL:  next_state.rdata = state.ctrl;
            jid_pkg::REG_FLAGS: next_state.rdata = {3'h0, state.flags};
            jid_pkg::REG_WORK:  next_state.rdata = state.work;
            jid_pkg::REG_PCLOW: next_state.rdata = state.pc[7:0];
         endcase
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= '0;
         state.phase <= jid_pkg::Q1;
         state.pc <= jid_pkg::PC_RESET;
         state.work <= jid_pkg::WORK_RESET;
         state.ctrl <= jid_pkg::CTRL_RESET;
      end
      else
         state <= next_state;
   end

   // Outputs straight from state
   assign memReq = state.mem;
   assign phase = state.phase;
   assign pc = state.pc;
   assign flags = state.flags;
   assign workReg = state.work;
   assign regRdata = state.rdata;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_jump_target;
      (state.phase == jid_pkg::Q4 && state.isJump && instrNext[15:12] == jid_pkg::JUMP_PREFIX)
         |=> pc == {$past(instrNext[11:0]), $past(state.kLow), 1'b0};
   endproperty
   a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

   property p_pc_even;
      pc[0] == 1'b0;
   endproperty
   a_pc_even: assert property (p_pc_even) else $error("pc bit 0 set");

   property p_jump_idle;
      (state.phase == jid_pkg::Q4 && state.isJump && instrNext[15:12] == jid_pkg::JUMP_PREFIX)
         |=> ##1 (!state.isJump && !state.isInc) [*4];
   endproperty
   a_jump_idle: assert property (p_jump_idle) else $error("jump tail not idle");

   property p_jump_flags;
      (state.phase == jid_pkg::Q1 && isJumpWord(instrWord) && !state.flush) |=> $stable(flags) [*4];
   endproperty
   a_jump_flags: assert property (p_jump_flags) else $error("jump changed flags");

   property p_inc_work;
      (state.phase == jid_pkg::Q4 && state.isInc && !state.dBit) |=> workReg == $past(state.sum[7:0]);
   endproperty
   a_inc_work: assert property (p_inc_work) else $error("work register not written");

   property p_inc_file;
      memReq.we |-> phase == jid_pkg::Q4 && state.isInc && state.dBit
                    && memReq.wdata == state.operand + 8'h01;
   endproperty
   a_inc_file: assert property (p_inc_file) else $error("bad file write");

   property p_bank;
      (state.phase == jid_pkg::Q1 && !state.flush && isIncWord(instrWord) && instrWord[jid_pkg::INC_A_BIT])
         |=> memReq.addr == {$past(bankSelect), $past(instrWord[7:0])};
   endproperty
   a_bank: assert property (p_bank) else $error("bank address wrong");

   property p_indexed;
      (state.phase == jid_pkg::Q1 && !instrWord[jid_pkg::INC_A_BIT] && state.ctrl[jid_pkg::CTRL_EXT_BIT]
       && instrWord[7:0] <= jid_pkg::INDEX_LIMIT)
         |=> memReq.addr == $past(indexBase) + {4'h0, $past(instrWord[7:0])};
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");

   property p_flags;
      (state.phase == jid_pkg::Q4 && state.isInc)
         |=> flags.z == ($past(state.operand) == 8'hFF) && flags.c == ($past(state.operand) == 8'hFF);
   endproperty
   a_flags: assert property (p_flags) else $error("increment flags wrong");

   property p_phase_walk;
      (phase == jid_pkg::Q1) |=> phase == jid_pkg::Q2 ##1 phase == jid_pkg::Q3 ##1 phase == jid_pkg::Q4;
   endproperty
   a_phase_walk: assert property (p_phase_walk) else $error("phase order broken");

   // A jump and its idle tail must never reach data memory
   // Guards against a stale increment strobe leaking into the tail
   property p_jump_no_write;
      (state.isJump || state.flush) |-> !memReq.we;
   endproperty
   a_jump_no_write: assert property (p_jump_no_write) else $error("jump wrote memory");

   // The idle tail decodes nothing, whatever word sits on the bus
   property p_tail_refused;
      (state.phase == jid_pkg::Q1 && state.flush) |=> !state.isJump && !state.isInc;
   endproperty
   a_tail_refused: assert property (p_tail_refused) else $error("tail word decoded");

   // Every cycle that is not a taken jump moves the counter by one word
   // A missed step here would silently skew every later fetch
   property p_pc_step;
      (state.phase == jid_pkg::Q4 && !(state.isJump && instrNext[15:12] == jid_pkg::JUMP_PREFIX))
         |=> pc == $past(pc) + jid_pkg::PC_STEP;
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc step wrong");

   // Destination in the working register leaves the file register alone
   property p_d0_keeps_file;
      (state.phase == jid_pkg::Q4 && state.isInc && !state.dBit) |-> !memReq.we;
   endproperty
   a_d0_keeps_file: assert property (p_d0_keeps_file) else $error("file written with d clear");

   // Write back to the file leaves the working register alone
   // A port write in the same cycle is a legal change, so it is excluded
   property p_d1_keeps_work;
      (state.phase == jid_pkg::Q4 && state.isInc && state.dBit && !regWr) |=> $stable(workReg);
   endproperty
   a_d1_keeps_work: assert property (p_d1_keeps_work) else $error("work changed with d set");

   // Access bank split for unbanked operands outside the indexed window
   property p_access_bank;
      (state.phase == jid_pkg::Q1 && !instrWord[jid_pkg::INC_A_BIT]
       && !(state.ctrl[jid_pkg::CTRL_EXT_BIT] && instrWord[7:0] <= jid_pkg::INDEX_LIMIT))
         |=> memReq.addr[7:0] == $past(instrWord[7:0])
             && memReq.addr[11:8] == (($past(instrWord[7:0]) < jid_pkg::ACCESS_SPLIT)
                                      ? jid_pkg::ACCESS_LOW : jid_pkg::ACCESS_HIGH);
   endproperty
   a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");

   // Sign, half carry and overflow follow the operand, not the stored sum
   // Judged from the operand so a broken adder cannot hide behind itself
   property p_flags_arith;
      (state.phase == jid_pkg::Q4 && state.isInc)
         |=> flags.dc == ($past(state.operand[3:0]) == 4'hF)
             && flags.ov == ($past(state.operand) == 8'h7F)
             && flags.n == ($past(state.operand) >= 8'h7F && $past(state.operand) != 8'hFF);
   endproperty
   a_flags_arith: assert property (p_flags_arith) else $error("increment sign flags wrong");

   c_jump: cover property (state.phase == jid_pkg::Q4 && state.isJump);
   c_inc_file: cover property (memReq.we);
   c_inc_work: cover property (state.phase == jid_pkg::Q4 && state.isInc && !state.dBit);
   c_wrap: cover property (state.phase == jid_pkg::Q4 && state.isInc && state.sum[8]);
   // Indexed operand decoded with the extended set on
   c_indexed: cover property (state.phase == jid_pkg::Q1 && !state.flush && isIncWord(instrWord)
                              && !instrWord[jid_pkg::INC_A_BIT] && state.ctrl[jid_pkg::CTRL_EXT_BIT]
                              && instrWord[7:0] <= jid_pkg::INDEX_LIMIT);

endmodule : jid_jump_and_increment_decode

// ==== rtl/jid_pkg.sv ====
// Shared constants, types and encodings for the jump and increment decoder
package jid_pkg;

   // Instruction cycle phases, one clock each
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} jid_phase_e;

   // Arithmetic status flags written by the increment
   typedef struct packed {
      logic n;   // Negative
      logic ov;  // Overflow
      logic z;   // Zero
      logic dc;  // Digit carry
      logic c;   // Carry
   } jid_flags_s;

   // Data memory request driven toward the core's file registers
   typedef struct packed {
      logic [11:0] addr;   // Byte address in data memory
      logic        we;     // Write strobe, one clock in Q4
      logic [7:0]  wdata;  // Write data
   } jid_mem_s;

   // Opcode fields
   localparam logic [7:0] JUMP_OPCODE    = 8'hEF;  // First jump word, upper byte
   localparam logic [3:0] JUMP_PREFIX    = 4'hF;   // Second jump word, top nibble
   localparam logic [5:0] INC_OPCODE     = 6'h0A;  // Increment, bits 15..10
   localparam int         INC_D_BIT      = 9;      // Destination select bit
   localparam int         INC_A_BIT      = 8;      // Bank select bit

   // Addressing constants
   localparam logic [7:0] INDEX_LIMIT    = 8'h5F;  // Highest indexed offset
   localparam logic [7:0] ACCESS_SPLIT   = 8'h60;  // Access bank low/high boundary
   localparam logic [3:0] ACCESS_HIGH    = 4'hF;   // Bank of upper access half
   localparam logic [3:0] ACCESS_LOW     = 4'h0;   // Bank of lower access half
   localparam logic [20:0] PC_STEP       = 21'h000002; // Bytes per instruction word
   localparam logic [8:0] INC_ONE        = 9'h001;
   localparam logic [7:0] SIGNED_MAX     = 8'h7F;

   // Register port map
   localparam logic [1:0] REG_CTRL       = 2'h0;   // Bit 0 enables extended set
   localparam logic [1:0] REG_FLAGS      = 2'h1;   // Status flags, read only
   localparam logic [1:0] REG_WORK       = 2'h2;   // Working register
   localparam logic [1:0] REG_PCLOW      = 2'h3;   // Program counter bits 7..0
   localparam int         CTRL_EXT_BIT   = 0;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] WORK_RESET     = 8'h00;
   localparam logic [20:0] PC_RESET      = 21'h000000;

endpackage : jid_pkg

// ==== testbench/jid_data_mem.sv ====
// Behavioural file register memory facing the decoder
`timescale 1ns/10ps
module jid_data_mem
(
   input  wire logic         clk,      // Core clock
   input  jid_pkg::jid_mem_s memReq,   // Address and write from the core
   output logic [7:0]        memRdata  // Read data for the current address
);
   logic [7:0] mem [0:4095];  // Whole data space, bench may preload it

   // Known pattern so every read has a defined value
   initial
   begin
      for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
   end

   // Writes land at the edge that ends the strobe cycle
   always @(posedge clk)
   begin
      if (memReq.we) mem[memReq.addr] <= memReq.wdata;
   end

   // Asynchronous read, settled well before the sampling edge
   assign memRdata = mem[memReq.addr];
endmodule : jid_data_mem

// ==== testbench/jid_jump_and_increment_decode_tb.sv ====
// Self-checking bench for the jump and increment decoder
`timescale 1ns/10ps
module jid_jump_and_increment_decode_tb;
   logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic [15:0] instrWord = 16'h0000, instrNext = 16'h0000;
   logic [3:0]  bankSelect = 4'h0;
   logic [11:0] indexBase = 12'h000;
   logic [1:0]  regAddr = 2'h0;
   logic [7:0]  regWdata = 8'h00, memRdata, workReg, regRdata, eWork = 8'h00;
   logic [20:0] pc, ePc = 21'h000000;    // Expected program counter
   jid_pkg::jid_mem_s   memReq;
   jid_pkg::jid_phase_e phase;
   jid_pkg::jid_flags_s flags, eFlags = 5'h00;
   logic eExt = 1'b0, skip = 1'b0;       // Extended set, idle tail pending
   logic [15:0] w, n;
   int err_total = 0, n_compared = 0;

   // Free-running 125 MHz clock
   always #4 clk = ~clk;

   jid_jump_and_increment_decode dut (.clk(clk), .rst(rst), .instrWord(instrWord), .instrNext(instrNext),
      .bankSelect(bankSelect), .indexBase(indexBase), .memRdata(memRdata), .memReq(memReq), .phase(phase),
      .pc(pc), .flags(flags), .workReg(workReg), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata));
   jid_data_mem u_mem (.clk(clk), .memReq(memReq), .memRdata(memRdata));

   task automatic checkVal(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : checkVal

   // Flags of v plus one
   function automatic jid_pkg::jid_flags_s incFlags(input logic [7:0] v);
      jid_pkg::jid_flags_s fl;
      fl.c = (v == 8'hFF);
      fl.dc = (v[3:0] == 4'hF);
      fl.z = (v == 8'hFF);
      fl.n = (v + 8'h01) >> 7;
      fl.ov = (v == 8'h7F);
      return fl;
   endfunction : incFlags

   // Data address from bank bit, bank select and index base
   function automatic logic [11:0] expAddr(input logic [7:0] f, input logic a, input logic [3:0] b,
                                           input logic [11:0] base);
      if (a) return {b, f};
      if (eExt && f <= 8'h5F) return base + {4'h0, f};
      return (f < 8'h60) ? {4'h0, f} : {4'hF, f};
   endfunction : expAddr

   task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : regWrite

   // Read data stand only in the cycle after the strobe
   task automatic regRead(input logic [1:0] a, input logic [7:0] exp);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      checkVal("regRdata", regRdata, exp);
      @(posedge clk);
      #1;
      checkVal("regRdata idle", regRdata, 8'h00);
   endtask : regRead

   // One four-clock instruction cycle, called just after a Q4 edge
   task automatic exec(input logic [15:0] wd, input logic [15:0] nx, input logic [8:0] pre = 9'h000);
      logic [7:0] v;
      logic [11:0] a;
      logic [3:0] bs;
      logic [11:0] ib;
      logic inc, jmp;
      logic [7:0] vp;
      bs = $urandom;
      ib = $urandom;
      inc = !skip && wd[15:10] == jid_pkg::INC_OPCODE;
      jmp = !skip && wd[15:8] == jid_pkg::JUMP_OPCODE && nx[15:12] == jid_pkg::JUMP_PREFIX;
      a = expAddr(wd[7:0], wd[jid_pkg::INC_A_BIT], bs, ib);
      if (inc && pre[8]) u_mem.mem[a] = pre[7:0];
      v = u_mem.mem[a];
      vp = v + 8'h01;  // Held at eight bits so the wrap to zero is what gets compared
      instrWord <= wd;
      instrNext <= nx;
      bankSelect <= bs;
      indexBase <= ib;
      @(posedge clk);
      #1;
      checkVal("phase", phase, jid_pkg::Q2);
      if (inc) checkVal("addr", memReq.addr, a);
      repeat (2) @(posedge clk);
      #1;
      checkVal("we", memReq.we, inc && wd[jid_pkg::INC_D_BIT]);
      if (inc && wd[jid_pkg::INC_D_BIT]) checkVal("wdata", memReq.wdata, vp);
      @(posedge clk);
      #1;
      // Model state after the Q4 edge
      ePc = jmp ? {nx[11:0], wd[7:0], 1'b0} : ePc + jid_pkg::PC_STEP;
      if (inc) eFlags = incFlags(v);
      if (inc && !wd[jid_pkg::INC_D_BIT]) eWork = vp;
      checkVal("pc", pc, ePc);
      checkVal("flags", flags, eFlags);
      checkVal("workReg", workReg, eWork);
      if (inc) checkVal("mem", u_mem.mem[a], wd[jid_pkg::INC_D_BIT] ? vp : v);
      skip = jmp;
   endtask : exec

   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run

   // Hang guard
   initial
   begin
      #800000;
      err_total++;
      complete_run();
   end

   // Main sequence: reset, register port, corners, then random traffic
   initial
   begin
      void'($urandom(47299));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      fork
         begin exec(16'h0000, 16'h0000); exec(16'h0000, 16'h0000); end
         begin regRead(jid_pkg::REG_CTRL, 8'h00); regRead(jid_pkg::REG_FLAGS, 8'h00);
            regRead(jid_pkg::REG_WORK, 8'h00); regRead(jid_pkg::REG_PCLOW, 8'h02); end
      join
      eWork = 8'h5A;  // Port write lands at the Q1 edge, before the check
      fork exec(16'h0000, 16'h0000); regWrite(jid_pkg::REG_WORK, 8'h5A); join
      // Carry, digit carry, overflow and sign corners across both destinations and banks
      exec(16'h2B10, 16'h0000, 9'h1FF);
      exec(16'h2911, 16'h0000, 9'h17F);
      exec(16'h2A70, 16'h0000, 9'h10F);
      // Core write to the working register wins over the port in Q4
      fork exec(16'h2820, 16'h0000, 9'h180); begin repeat (3) @(posedge clk); regWrite(jid_pkg::REG_WORK, 8'h3C); end join
      exec(16'hEFFF, 16'hFFFF);
      exec(16'h2B10, 16'h0000);
      exec(16'hEF12, 16'h7345);
      exec(16'hEF00, 16'hF000);
      fork exec(16'h0000, 16'h0000); regWrite(jid_pkg::REG_CTRL, 8'h01); join
      eExt = 1'b1;
      exec(16'h2A5F, 16'h0000);
      exec(16'h2A60, 16'h0000);
      for (int i = 0; i < 300; i++)
      begin
         w = $urandom;
         n = $urandom;
         if (i % 3 == 0) w[15:10] = jid_pkg::INC_OPCODE;
         if (i % 3 == 1) w[15:8] = jid_pkg::JUMP_OPCODE;
         if (i % 4 != 0) n[15:12] = jid_pkg::JUMP_PREFIX;
         if (i == 150)
         begin
            fork exec(w, n); regWrite(jid_pkg::REG_CTRL, 8'h00); join
            eExt = 1'b0;
         end
         else
            exec(w, n);
      end
      complete_run();
   end
endmodule : jid_jump_and_increment_decode_tb
